// file: verilog/dsc_config_decoder.sv
// switch configuration decoder with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dsc_config_decoder
    import dsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [dsc_pkg::SW_W-1:0] sw_raw_i,
    input wire logic [dsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [dsc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [dsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [dsc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [dsc_pkg::NODE_W-1:0] node_id_o,
    output logic cfg_valid_o,
    output logic exception_report_enable_o,
    output logic smart_instruction_enable_o,
    output logic write_protect_o,
    output logic [dsc_pkg::DATA_W-1:0] ip_addr_o
);
    dsc_sw_if sw_bus ();

    dsc_sw_sampler u_sampler (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .sw_raw_i(sw_raw_i),
        .sw_o(sw_bus.src)
    );

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] nw, input logic [3:0] st);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [NODE_W-1:0] soft_node_r, eff_r;
    logic [DATA_W-1:0] ip_r, name_r, pcfg_r;
    logic [ERR_W-1:0] err_r;
    logic feat_r, prot_r;
    logic [ID_W-1:0] sw_id;
    logic protect, wr_fire, wr_go, rd_go, wr_hit, rd_hit;
    logic node_rej, pcfg_rej, ip_rej;
    logic [ERR_W-1:0] err_set;
    logic [DATA_W-1:0] wr_merged, rd_mux;

    assign sw_id = sw_bus.valid ? sw_bus.sw[ID_W-1:0] : '0;
    assign protect = sw_bus.valid && sw_bus.sw[BIT_PROTECT];
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
    assign wr_fire = awready_r;
    assign rd_go = s_axi_arvalid && !arready_r && !rvalid_r;

    // software identifier only while switches read zero
    assign node_rej = (sw_id != '0) || protect || !sw_bus.valid;
    assign pcfg_rej = protect;
    assign ip_rej = protect;

    always_comb
    begin
        wr_merged = '0;
        wr_hit = 1'b1;
        err_set = '0;
        case (s_axi_awaddr)
            OFS_NODE: wr_merged = merge({{(DATA_W-NODE_W){1'b0}}, soft_node_r},
                s_axi_wdata, s_axi_wstrb);
            OFS_IP: wr_merged = merge(ip_r, s_axi_wdata, s_axi_wstrb);
            OFS_NAME: wr_merged = merge(name_r, s_axi_wdata, s_axi_wstrb);
            OFS_PCFG: wr_merged = merge(pcfg_r, s_axi_wdata, s_axi_wstrb);
            OFS_ERR: wr_merged = s_axi_wdata;
            OFS_SWITCH, OFS_EFF: wr_merged = '0;
            default: wr_hit = 1'b0;
        endcase
        if (wr_fire && s_axi_awaddr == OFS_NODE && node_rej)
            err_set[ERR_ID] = 1'b1;
        if (wr_fire && ((s_axi_awaddr == OFS_PCFG && pcfg_rej)
            || (s_axi_awaddr == OFS_IP && ip_rej)))
            err_set[ERR_PROT] = 1'b1;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            awready_r <= wr_go;
            wready_r <= wr_go;
            if (wr_fire)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            soft_node_r <= NODE_RST;
        else if (wr_fire && s_axi_awaddr == OFS_NODE && !node_rej)
            soft_node_r <= wr_merged[NODE_W-1:0];
    end

    // recovery at capture overrides any same-cycle write
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            ip_r <= IP_DEFAULT;
        else if (sw_bus.pulse && sw_bus.sw[BIT_RECOVER])
            ip_r <= IP_DEFAULT;
        else if (wr_fire && s_axi_awaddr == OFS_IP && !ip_rej)
            ip_r <= wr_merged;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            name_r <= NAME_RST;
        else if (wr_fire && s_axi_awaddr == OFS_NAME)
            name_r <= wr_merged;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pcfg_r <= PCFG_RST;
        else if (wr_fire && s_axi_awaddr == OFS_PCFG && !pcfg_rej)
            pcfg_r <= wr_merged;
    end

    // sticky errors, write one to clear, set beats clear
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            err_r <= '0;
        else if (wr_fire && s_axi_awaddr == OFS_ERR)
            err_r <= (err_r & ~wr_merged[ERR_W-1:0]) | err_set;
        else
            err_r <= err_r | err_set;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            eff_r <= NODE_RST;
            feat_r <= 1'b0;
            prot_r <= 1'b0;
        end
        else
        begin
            eff_r <= (sw_id != '0) ? NODE_W'(sw_id) : soft_node_r;
            feat_r <= sw_bus.valid && sw_bus.sw[BIT_FEATURE];
            prot_r <= protect;
        end
    end

    always_comb
    begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_SWITCH: rd_mux = {{(DATA_W-SW_W-1){1'b0}}, sw_bus.valid, sw_bus.sw};
            OFS_NODE: rd_mux = {{(DATA_W-NODE_W){1'b0}}, soft_node_r};
            OFS_EFF: rd_mux = {{(DATA_W-NODE_W){1'b0}}, eff_r};
            OFS_IP: rd_mux = ip_r;
            OFS_NAME: rd_mux = name_r;
            OFS_PCFG: rd_mux = pcfg_r;
            OFS_ERR: rd_mux = {{(DATA_W-ERR_W){1'b0}}, err_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            arready_r <= rd_go;
            if (arready_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign node_id_o = eff_r;
    assign cfg_valid_o = sw_bus.valid;
    assign exception_report_enable_o = feat_r;
    assign smart_instruction_enable_o = feat_r;
    assign write_protect_o = prot_r;
    assign ip_addr_o = ip_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_SW_ID: assert property (sw_bus.valid && sw_id != '0 |=>
        node_id_o == NODE_W'($past(sw_bus.sw[ID_W-1:0])))
        else $error("effective id differs from switch id");
    AST_SOFT_ID: assert property (sw_id == '0 |=> node_id_o == $past(soft_node_r))
        else $error("effective id not software id");
    AST_ID_REJECT: assert property (wr_fire && s_axi_awaddr == OFS_NODE
        && sw_id != '0 |=> $stable(soft_node_r) && err_r[ERR_ID])
        else $error("software id write not rejected");
    AST_NAME_WR: assert property (wr_fire && s_axi_awaddr == OFS_NAME
        && s_axi_wstrb == 4'hF |=> name_r == $past(s_axi_wdata))
        else $error("name write lost");
    AST_RECOVER: assert property (sw_bus.pulse && sw_bus.sw[BIT_RECOVER] |=>
        ip_addr_o == IP_DEFAULT)
        else $error("ip not restored on recover");
    AST_PROTECT: assert property (protect && wr_fire && s_axi_awaddr == OFS_PCFG |=>
        $stable(pcfg_r) ##1 err_r[ERR_PROT])
        else $error("protected write took effect");
    AST_FEATURE: assert property (##1 exception_report_enable_o ==
        $past(sw_bus.valid && sw_bus.sw[BIT_FEATURE]))
        else $error("feature enable mismatch");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    COV_ID_REJ: cover property (wr_fire && s_axi_awaddr == OFS_NODE && node_rej);
    COV_RECOVER: cover property (sw_bus.pulse && sw_bus.sw[BIT_RECOVER]);
    COV_PROT: cover property (protect && wr_fire && s_axi_awaddr == OFS_PCFG);
    COV_SOFT: cover property (sw_bus.valid && sw_id == '0 ##1 node_id_o != '0);
endmodule
`default_nettype wire

// file: verilog/dsc_pkg.sv
// constants for the switch sampler and configuration decoder
package dsc_pkg;
    localparam int unsigned SW_W = 8;
    localparam int unsigned ID_W = 6;
    localparam int unsigned NODE_W = 30;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BIT_PROTECT = 5;
    localparam int unsigned BIT_RECOVER = 6;
    localparam int unsigned BIT_FEATURE = 7;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned SETTLE_NS = 1000;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 8;
    localparam logic [ADDR_W-1:0] OFS_SWITCH = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_NODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EFF = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IP = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_NAME = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PCFG = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_ERR = 8'h18;
    localparam logic [NODE_W-1:0] NODE_RST = 30'h0000_0000;
    localparam logic [DATA_W-1:0] IP_DEFAULT = 32'h0000_0000;
    localparam logic [DATA_W-1:0] NAME_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PCFG_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned ERR_ID = 0;
    localparam int unsigned ERR_PROT = 1;
    localparam int unsigned ERR_W = 2;
endpackage

// file: verilog/dsc_sw_if.sv
// carrier for latched switch settings between sampler and decoder
`timescale 1ns/1ps
`default_nettype none
interface dsc_sw_if;
    import dsc_pkg::*;
    logic [SW_W-1:0] sw;
    logic valid;
    logic pulse;
    modport src (output sw, output valid, output pulse);
    modport dst (input sw, input valid, input pulse);
endinterface
`default_nettype wire

// file: verilog/dsc_sw_sampler.sv
// switch synchroniser and one-shot power-up latch
`timescale 1ns/1ps
`default_nettype none
module dsc_sw_sampler
    import dsc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [dsc_pkg::SW_W-1:0] sw_raw_i,
    dsc_sw_if.src sw_o
);
    logic [SW_W-1:0] sync1_r;
    logic [SW_W-1:0] sync2_r;
    logic [SW_W-1:0] latch_r;
    logic [CNT_W-1:0] cnt_r;
    logic valid_r;
    logic pulse_r;
    logic take;

    assign take = !valid_r && (cnt_r == CNT_W'(SETTLE_CYC - 1));

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= sw_raw_i;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_r <= '0;
        else if (!valid_r)
            cnt_r <= cnt_r + CNT_W'(1);
    end

    // single capture after release, frozen until next reset
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            latch_r <= '0;
            valid_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else
        begin
            pulse_r <= take;
            if (take)
            begin
                latch_r <= sync2_r;
                valid_r <= 1'b1;
            end
        end
    end

    assign sw_o.sw = latch_r;
    assign sw_o.valid = valid_r;
    assign sw_o.pulse = pulse_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_LATCH_HOLD: assert property (valid_r |=> valid_r && $stable(latch_r))
        else $error("latched switches changed after capture");
    AST_ONE_SHOT: assert property (pulse_r |=> !pulse_r ##1 !pulse_r)
        else $error("capture pulse repeated");
    AST_SETTLE_TIME: assert property ($rose(valid_r) |-> cnt_r == CNT_W'(SETTLE_CYC))
        else $error("capture at wrong time after reset");
endmodule
`default_nettype wire

// file: testbench/dsc_dip_switch.sv
// model of the hand-set eight-position switch, with contact bounce
`timescale 1ns/1ps
`default_nettype none
module dsc_dip_switch
(
    input wire logic [7:0] pos_i,
    output var logic [7:0] sw_o
);
    initial sw_o = 8'h00;
    // any move shows the inverse of the new setting on all eight outputs for 2 ns before it settles
    always @(pos_i)
    begin
        sw_o = ~pos_i;
        #2;
        sw_o = pos_i;
    end
endmodule
`default_nettype wire

// file: testbench/dip_switch_config_decoder_tb.sv
// self-checking bench for the switch configuration decoder
`timescale 1ns/1ps
`default_nettype none
module dip_switch_config_decoder_tb;
    import dsc_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] sw_set = 8'h00;
    logic [7:0] sw_raw;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, cfg_valid, exc_en, smart_en, wprot;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, ip_addr;
    logic [29:0] node_id;
    logic [1:0] resp;
    logic [31:0] rd;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int rel_cyc = 0;

    always #2.5 core_clk = ~core_clk;

    dsc_dip_switch sw_u (.pos_i(sw_set), .sw_o(sw_raw));

    dsc_config_decoder dut_u (
        .core_clk_i(core_clk), .resetn_i(resetn), .sw_raw_i(sw_raw),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .node_id_o(node_id),
        .cfg_valid_o(cfg_valid), .exception_report_enable_o(exc_en),
        .smart_instruction_enable_o(smart_en), .write_protect_o(wprot),
        .ip_addr_o(ip_addr));

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            $display("wrong value at %0t: bench timed out", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge core_clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rst(input logic [7:0] sw);
        @(posedge core_clk);
        resetn <= 1'b0;
        sw_set <= sw;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        rel_cyc = cyc;
    endtask

    // counts edges from release until capture is flagged
    task automatic wait_cfg();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n = cyc - rel_cyc;
        end
        while (cfg_valid !== 1'b1 && n < 400);
        chk(n, SETTLE_CYC);
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // all six id switches on: maximum id, protect also on
    task automatic scn_max_protect();
        rst(8'h3F);
        wait_cfg();
        chk(node_id, 63);
        chk(wprot, 1);
        chk({exc_en, smart_en}, 0);
        axw(OFS_NODE, 32'h0000_0005, resp);
        axr(OFS_ERR, rd, resp);
        chk(rd[0], 1);
        chk(node_id, 63);
        axw(OFS_IP, 32'hC0A8_6405, resp);
        axr(OFS_ERR, rd, resp);
        chk(rd[1], 1);
        chk(ip_addr, IP_DEFAULT);
        axw(OFS_PCFG, 32'h0000_00A5, resp);
        axr(OFS_PCFG, rd, resp);
        chk(rd, PCFG_RST);
        axw(OFS_ERR, 32'h0000_0003, resp);
        axr(OFS_ERR, rd, resp);
        chk(rd, 0);
        axw(OFS_NAME, 32'h5075_6D70, resp);
        axr(OFS_NAME, rd, resp);
        chk(rd, 32'h5075_6D70);
        sw_set <= 8'h80;
        repeat (20) @(posedge core_clk);
        #1;
        chk(node_id, 63);
        chk({exc_en, wprot}, 2'h1);
        axr(OFS_SWITCH, rd, resp);
        chk(rd[8:0], 9'h13F);
    endtask

    // weights of positions 0, 1, 3 plus feature switch
    task automatic scn_weights_features();
        rst(8'h8B);
        wait_cfg();
        chk(node_id, 11);
        chk({exc_en, smart_en, wprot}, 3'h6);
        axr(OFS_EFF, rd, resp);
        chk(rd, 11);
        axr(8'h1C, rd, resp);
        chk(resp, RESP_SLVERR);
        axw(8'h1C, 32'h0000_0001, resp);
        chk(resp, RESP_SLVERR);
    endtask

    // all id switches off: software id and ip accepted
    task automatic scn_software_id();
        rst(8'h00);
        axw(OFS_IP, 32'hC0A8_6401, resp);
        wait_cfg();
        chk(ip_addr, 32'hC0A8_6401);
        chk(node_id, 0);
        axw(OFS_NODE, 32'h0000_005A, resp);
        chk(resp, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        #1;
        chk(node_id, 90);
        axr(OFS_ERR, rd, resp);
        chk(rd[0], 0);
        axw(OFS_IP, 32'hC0A8_6402, resp);
        repeat (2) @(posedge core_clk);
        #1;
        chk(ip_addr, 32'hC0A8_6402);
        axw(OFS_PCFG, 32'h0000_00A5, resp);
        axr(OFS_PCFG, rd, resp);
        chk(rd, 32'h0000_00A5);
        wstrb <= 4'h1;
        axw(OFS_NAME, 32'hFFFF_FF12, resp);
        wstrb <= 4'hF;
        axr(OFS_NAME, rd, resp);
        chk(rd, 32'h0000_0012);
    endtask

    // recover switch: ip written before capture goes back to default
    task automatic scn_recover();
        rst(8'h40);
        axw(OFS_IP, 32'hC0A8_6403, resp);
        #1;
        chk(ip_addr, 32'hC0A8_6403);
        wait_cfg();
        chk(ip_addr, IP_DEFAULT);
        chk(node_id, 0);
    endtask

    initial
    begin
        rst(8'h00);
        scn_max_protect();
        scn_weights_features();
        scn_software_id();
        scn_recover();
        tally_and_finish();
    end
endmodule
`default_nettype wire
